//--- core/gate_driver_fault_supervisor.sv
// fault supervisor for a three half-bridge gate driver
// Operation
// - supply lockout releases gates, stops pump, alarms
// - supply recovery automatic; flag held until cleared
// - unmasked pump low releases gates and alarms
// - masked pump low only sets flag
// - strapped variant cannot mask pump low
// - overcurrent needs enabled fet, longer than filter
// - strapped: fixed filter, latched, strap disables
// - register variant: level, filter, response select
// - latched: gates off until clear and condition gone
// - response selector resets to latched
// - retry: shutdown then auto resume after interval
// - report only: gates run, alarm until cleared
// - disabled: monitor off, bridge masks locked
// - checksum fault alarms only, no action
// - global flag is or of all flags
// assumes: apb master on pclk; analog comparators synchronous
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "fault_sup_defines.svh"
module gate_driver_fault_supervisor
#(
   parameter int RETRY_CYCLES = `RETRY_CYC,
   parameter int CNT_W = 12
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic strap_variant,
   input wire logic trip_level_strap_at_logic_supply,
   input wire logic supply_lockout,
   input wire logic pump_low,
   input wire logic [5:0] drain_source_over,
   input wire logic [5:0] fet_enabled,
   input wire logic checksum_done,
   input wire logic checksum_fail,
   input wire logic enable_reset_pulse,
   output logic gates_release,
   output logic pump_stop,
   output logic alarm_pin_low,
   output logic [3:0] drain_source_trip_level,
   output logic irq
);
   import fault_sup_pkg::*;

   initial
   begin
      if (RETRY_CYCLES < 1 || RETRY_CYCLES > 65535)
         $error("retry count out of range");
      if (CNT_W < 11)
         $error("filter counter too narrow for longest filter time");
   end

   // filter limit from the 4-bit time code, one step per code
   function automatic logic [CNT_W-1:0] filt_cycles(input logic [3:0] code);
      filt_cycles = CNT_W'((int'(code) + 1) * `DEG_STEP_CYC);
   endfunction

   // apb decode
   wire logic setup_rd = psel && !penable && !pwrite;
   wire logic acc = psel && penable;
   wire logic wr = acc && pwrite;
   wire logic hit_status = paddr == `ADDR_STATUS;
   wire logic hit_control = paddr == `ADDR_CONTROL;
   wire logic hit_live = paddr == `ADDR_LIVE;
   wire logic hit_istat = paddr == `ADDR_IRQ_STATUS;
   wire logic hit_imask = paddr == `ADDR_IRQ_MASK;
   wire logic mapped = hit_status | hit_control | hit_live | hit_istat
      | hit_imask;

   // state registers
   logic strap_reg; // variant caught after reset release
   logic strap_taken_reg; // strap already sampled
   logic [15:0] control_reg; // software configuration
   logic supply_flag_reg; // supply_low_flag
   logic pump_flag_reg; // pump_low_flag
   logic checksum_flag_reg; // memory checksum alarm
   logic [5:0] fet_flag_reg; // per-mosfet overcurrent flags
   logic [3:0] irq_status_reg; // sticky events
   logic [3:0] irq_mask_reg; // enables onto irq
   logic [31:0] prdata_reg; // read data
   logic supply_seen_reg; // supply lockout last cycle
   logic pump_seen_reg; // pump low last cycle
   logic [15:0] retry_cnt_reg; // retry interval counter
   oc_state_t oc_state_reg; // retry sequencer
   logic [15:0] control_next;
   logic [15:0] retry_cnt_next;
   oc_state_t oc_state_next;

   // effective configuration, strapped variant overrides
   wire logic clear_alarms_cmd = control_reg[`CT_CLEAR];
   wire logic pump_low_mask = control_reg[`CT_PUMP_MASK] && !strap_reg;
   wire logic [1:0] sel_field = control_reg[`CT_RESP_HI:`CT_RESP_LO];
   wire oc_resp_t overcurrent_response_sel = !strap_reg ? oc_resp_t'(sel_field)
      : (trip_level_strap_at_logic_supply ? RESP_DISABLED : RESP_LATCHED);
   wire logic [2:0] per_bridge_overcurrent_mask =
      control_reg[`CT_BRIDGE_HI:`CT_BRIDGE_LO];
   wire logic [3:0] overcurrent_filter_time =
      control_reg[`CT_FILT_HI:`CT_FILT_LO];
   wire logic [CNT_W-1:0] filt_limit = strap_reg ? CNT_W'(`DEG_FIXED_CYC)
      : filt_cycles(overcurrent_filter_time);
   wire logic oc_off = overcurrent_response_sel == RESP_DISABLED;
   wire logic clear_now = clear_alarms_cmd || enable_reset_pulse;

   // per-mosfet filters; bridge b owns fets 2b and 2b+1
   logic [5:0] fet_trip;
   logic [5:0] fet_event;
   logic [5:0] fet_active;
   genvar g;
   generate
      for (g = 0; g < 6; g++)
      begin : gen_filt
         assign fet_active[g] = drain_source_over[g] && fet_enabled[g]
            && !oc_off && !per_bridge_overcurrent_mask[g/2];
         overcurrent_filter #(.CNT_W(CNT_W)) u_filt
         (
            .pclk(pclk),
            .presetn(presetn),
            .active(fet_active[g]),
            .limit(filt_limit),
            .trip(fet_trip[g]),
            .trip_event(fet_event[g])
         );
      end
   endgenerate

   wire logic oc_any_event = |fet_event;
   wire logic oc_flag = |fet_flag_reg;
   wire logic retry_mode = overcurrent_response_sel == RESP_RETRY;
   wire logic retry_done = oc_state_reg == OC_WAIT
      && retry_cnt_reg == 16'(RETRY_CYCLES - 1);
   wire logic global_flag = supply_flag_reg | pump_flag_reg | oc_flag
      | checksum_flag_reg;
   wire logic pump_block = pump_low && !pump_low_mask;
   wire logic oc_block = oc_flag && (overcurrent_response_sel == RESP_LATCHED
      || overcurrent_response_sel == RESP_RETRY);
   wire logic oc_alarm = oc_flag && !oc_off;

   // flag next values: a new fault wins over a clear
   wire logic supply_flag_next = supply_lockout
      || (supply_flag_reg && !clear_now);
   wire logic pump_flag_next = pump_low
      || (pump_flag_reg && !clear_now);
   logic [5:0] fet_flag_next;
   always_comb
   begin
      for (int i = 0; i < 6; i++)
      begin
         // retry clears at expiry; others need clear and gone condition
         if (fet_event[i])
            fet_flag_next[i] = 1'b1;
         else if (retry_done)
            fet_flag_next[i] = 1'b0;
         else if (clear_now && !drain_source_over[i] && !retry_mode)
            fet_flag_next[i] = 1'b0;
         else
            fet_flag_next[i] = fet_flag_reg[i];
      end
   end

   // retry sequencer
   always_comb
   begin
      oc_state_next = oc_state_reg;
      retry_cnt_next = retry_cnt_reg;
      case (oc_state_reg)
         OC_IDLE:
         begin
            if (oc_any_event && retry_mode)
            begin
               oc_state_next = OC_WAIT;
               retry_cnt_next = '0;
            end
         end
         OC_WAIT:
         begin
            if (retry_done || !retry_mode)
               oc_state_next = OC_IDLE;
            retry_cnt_next = retry_cnt_reg + 16'h0001;
         end
         default:
            oc_state_next = OC_IDLE;
      endcase
   end

   // control writes; bridge masks locked while monitor disabled
   always_comb
   begin
      control_next = control_reg;
      control_next[`CT_CLEAR] = 1'b0;
      if (wr && hit_control)
      begin
         control_next = pwdata[15:0];
         control_next[7] = 1'b0;
         if (oc_off)
            control_next[`CT_BRIDGE_HI:`CT_BRIDGE_LO] =
               per_bridge_overcurrent_mask;
      end
   end

   // interrupt events and write-one-to-clear, set wins
   wire logic [3:0] irq_events = {checksum_done && checksum_fail,
      oc_any_event, pump_low && !pump_seen_reg,
      supply_lockout && !supply_seen_reg};
   wire logic [3:0] irq_wclr = (wr && hit_istat) ? pwdata[3:0] : 4'h0;
   wire logic [3:0] irq_status_next = irq_events
      | (irq_status_reg & ~irq_wclr);

   // read data mux
   wire logic [31:0] rd_mux =
      hit_status ? {21'h00_0000, fet_flag_reg, checksum_flag_reg, oc_flag,
         pump_flag_reg, supply_flag_reg, global_flag} :
      hit_control ? {16'h0000, control_reg} :
      hit_live ? {22'h00_0000, fet_trip, checksum_flag_reg, 1'b0,
         pump_low, supply_lockout} :
      hit_istat ? {28'h000_0000, irq_status_reg} :
      hit_imask ? {28'h000_0000, irq_mask_reg} : 32'h0000_0000;

   // configuration and flag registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         control_reg <= `CONTROL_RESET;
         supply_flag_reg <= 1'b0;
         pump_flag_reg <= 1'b0;
         fet_flag_reg <= 6'h00;
         checksum_flag_reg <= 1'b0;
      end
      else
      begin
         control_reg <= control_next;
         supply_flag_reg <= supply_flag_next;
         pump_flag_reg <= pump_flag_next;
         fet_flag_reg <= fet_flag_next;
         if (checksum_done && checksum_fail)
            checksum_flag_reg <= 1'b1;
      end
   end

   // strap capture, edge history, retry, interrupts, read data
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         strap_reg <= 1'b0;
         strap_taken_reg <= 1'b0;
         supply_seen_reg <= 1'b0;
         pump_seen_reg <= 1'b0;
         oc_state_reg <= OC_IDLE;
         retry_cnt_reg <= 16'h0000;
         irq_status_reg <= 4'h0;
         irq_mask_reg <= `IRQ_MASK_RESET;
         prdata_reg <= 32'h0000_0000;
      end
      else
      begin
         if (!strap_taken_reg)
            strap_reg <= strap_variant;
         strap_taken_reg <= 1'b1;
         supply_seen_reg <= supply_lockout;
         pump_seen_reg <= pump_low;
         oc_state_reg <= oc_state_next;
         retry_cnt_reg <= retry_cnt_next;
         irq_status_reg <= irq_status_next;
         if (wr && hit_imask)
            irq_mask_reg <= pwdata[3:0];
         if (setup_rd)
            prdata_reg <= rd_mux;
      end
   end

   // outputs
   assign pready = acc;
   assign pslverr = acc && !mapped;
   assign prdata = prdata_reg;
   assign gates_release = supply_lockout || pump_block || oc_block;
   assign pump_stop = supply_lockout;
   assign alarm_pin_low = !(supply_lockout || pump_block || oc_alarm
      || checksum_flag_reg);
   assign drain_source_trip_level = control_reg[`CT_LEVEL_HI:`CT_LEVEL_LO];
   assign irq = |(irq_status_reg & irq_mask_reg);

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_fet_trip;
      fet_active[0] [*2] ##0 $rose(fet_trip[0]);
   endsequence
   sequence s_retry_wait;
      oc_state_reg == OC_WAIT && retry_cnt_reg == 16'h0000;
   endsequence

   a_supply_shut: assert property (supply_lockout |-> gates_release && pump_stop
      && !alarm_pin_low) else $error("supply lockout not acted on");
   a_supply_hold: assert property (supply_lockout ##1 !supply_lockout
      && !clear_now |=> supply_flag_reg) else $error("supply flag lost");
   a_pump_block: assert property (pump_low && !pump_low_mask && !supply_lockout
      |-> gates_release && !alarm_pin_low) else $error("pump low missed");
   a_pump_masked: assert property (pump_low && pump_low_mask && !oc_block
      && !supply_lockout |-> !gates_release ##1 pump_flag_reg)
      else $error("masked pump low acted");
   a_strap_nomask: assert property (strap_reg |-> !pump_low_mask)
      else $error("strapped variant masked pump");
   a_filt_need: assert property ($rose(fet_trip[0]) |-> $past(fet_active[0]))
      else $error("trip without active input");
   a_strap_fixed: assert property (strap_reg |-> filt_limit == 12'd500)
      else $error("fixed filter time wrong");
   a_flag_latch: assert property (s_fet_trip |-> fet_flag_reg[0] || oc_off
      || retry_done) else $error("overcurrent flag not set");
   a_latch_gates: assert property (oc_flag && overcurrent_response_sel ==
      RESP_LATCHED |-> gates_release) else $error("latched gates on");
   a_retry_time: assert property (s_retry_wait ##1 retry_mode [*8] |->
      oc_state_reg == OC_WAIT) else $error("retry ended early");
   a_report_run: assert property (oc_flag && overcurrent_response_sel ==
      RESP_REPORT && !supply_lockout && !pump_block |-> !gates_release
      && !alarm_pin_low) else $error("report mode wrong");
   a_mask_lock: assert property (oc_off && wr && hit_control |=>
      $stable(per_bridge_overcurrent_mask)) else $error("mask not locked");
   a_checksum_alarm: assert property (checksum_flag_reg |-> !alarm_pin_low)
      else $error("checksum alarm missing");
   a_global_or: assert property (acc && !pwrite && hit_status |->
      prdata_reg[`ST_GLOBAL] == |prdata_reg[10:1])
      else $error("global flag not or");
   a_clear_self: assert property (clear_alarms_cmd |=> !clear_alarms_cmd)
      else $error("clear bit stuck");
endmodule

//--- core/fault_sup_defines.svh
// register offsets, field positions, reset values and timing counts
// assumes: included by the supervisor module and the testbench by bare name
`ifndef FAULT_SUP_DEFINES_SVH
`define FAULT_SUP_DEFINES_SVH

// byte addresses of the apb registers
`define ADDR_STATUS 8'h00
`define ADDR_CONTROL 8'h04
`define ADDR_LIVE 8'h08
`define ADDR_IRQ_STATUS 8'h10
`define ADDR_IRQ_MASK 8'h14

// status register fields
`define ST_GLOBAL 0
`define ST_SUPPLY 1
`define ST_PUMP 2
`define ST_OC 3
`define ST_CHECKSUM 4
`define ST_FET_LO 5
`define ST_FET_HI 10

// control register fields
`define CT_CLEAR 0
`define CT_PUMP_MASK 1
`define CT_RESP_LO 2
`define CT_RESP_HI 3
`define CT_BRIDGE_LO 4
`define CT_BRIDGE_HI 6
`define CT_LEVEL_LO 8
`define CT_LEVEL_HI 11
`define CT_FILT_LO 12
`define CT_FILT_HI 15

// interrupt event bits
`define IRQ_SUPPLY 0
`define IRQ_PUMP 1
`define IRQ_OC 2
`define IRQ_CHECKSUM 3

// reset values
`define CONTROL_RESET 16'h0000
`define IRQ_MASK_RESET 4'h0

// timing: clock period, fixed filter time, filter step, retry time
`define CLK_PERIOD_NS 8
`define DEG_FIXED_NS 4000
`define DEG_STEP_NS 1000
`define RETRY_NS 8000
`define DEG_FIXED_CYC ((`DEG_FIXED_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEG_STEP_CYC ((`DEG_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RETRY_CYC (`RETRY_NS / `CLK_PERIOD_NS)

`endif

//--- core/fault_sup_pkg.sv
// types shared by the fault supervisor files
// assumes: constants come from the defines header
package fault_sup_pkg;
   // overcurrent response selector codes
   typedef enum logic [1:0]
   {
      RESP_LATCHED = 2'b00,
      RESP_RETRY = 2'b01,
      RESP_REPORT = 2'b10,
      RESP_DISABLED = 2'b11
   } oc_resp_t;

   // retry sequencer states
   typedef enum logic
   {
      OC_IDLE,
      OC_WAIT
   } oc_state_t;
endpackage

//--- core/overcurrent_filter.sv
// deglitch filter for one mosfet drain-source comparator
// assumes: comparator input synchronous to pclk
`timescale 1ns/1ps
module overcurrent_filter
#(
   parameter int CNT_W = 12
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic active,
   input wire logic [CNT_W-1:0] limit,
   output logic trip,
   output logic trip_event
);
   initial
   begin
      if (CNT_W < 4)
         $error("overcurrent_filter: CNT_W too small");
   end

   logic [CNT_W-1:0] cnt_reg; // consecutive active cycles
   logic [CNT_W-1:0] cnt_next;
   logic trip_reg;
   logic trip_next;
   wire logic cnt_full;

   // saturate so a long fault never wraps back to zero
   assign cnt_full = &cnt_reg;
   assign cnt_next = !active ? '0 : (cnt_full ? cnt_reg : cnt_reg + 1'b1);
   // trips only when high longer than the limit
   assign trip_next = active && (cnt_reg >= limit);
   assign trip = trip_reg;
   assign trip_event = trip_next && !trip_reg;

   // counter and trip flag
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_reg <= '0;
         trip_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         trip_reg <= trip_next;
      end
   end
endmodule

//--- test/fet_stage_model.sv
// behavioural model of the six external power mosfets and their
// drain-source comparators
// assumes: commands change just after a rising pclk edge
`timescale 1ns/1ps
module fet_stage_model
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [5:0] fet_cmd,
   input wire logic [5:0] overload,
   input wire logic gates_release,
   output logic [5:0] fet_enabled,
   output logic [5:0] drain_source_over
);
   // controller command reaches the supervisor unchanged
   assign fet_enabled = fet_cmd;

   // comparator output: a released gate carries no load current, so
   // the overcurrent disappears once the supervisor shuts down;
   // a mosfet commanded off blocks the supply, so its comparator reads high
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         drain_source_over <= 6'h00;
      else
         drain_source_over <= (overload & fet_cmd & ~{6{gates_release}})
            | ~fet_cmd;
   end
endmodule

//--- test/testbench.sv
// self-checking bench for the gate driver fault supervisor
// assumes: design files and the mosfet stage model compiled first
`timescale 1ns/1ps
`include "fault_sup_defines.svh"
module testbench;
   import fault_sup_pkg::*;
   localparam int RETRY = 200; // shortened retry interval, cycles
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic strap_variant;
   logic strap_off; // trip level strap tied to the logic supply
   logic supply_lockout;
   logic pump_low;
   logic [5:0] fet_cmd; // controller gate commands
   logic [5:0] overload; // load fault on each mosfet
   logic [5:0] fet_enabled;
   logic [5:0] drain_source_over;
   logic checksum_done;
   logic checksum_fail;
   logic enable_reset_pulse;
   logic gates_release;
   logic pump_stop;
   logic alarm_pin_low;
   logic [3:0] drain_source_trip_level;
   logic irq;
   logic [31:0] rd; // last read data
   logic err; // last slave error
   int errors;
   int checks_done;

   gate_driver_fault_supervisor #(.RETRY_CYCLES(RETRY), .CNT_W(12))
   gate_driver_fault_supervisor_inst
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .strap_variant(strap_variant),
      .trip_level_strap_at_logic_supply(strap_off),
      .supply_lockout(supply_lockout), .pump_low(pump_low),
      .drain_source_over(drain_source_over), .fet_enabled(fet_enabled),
      .checksum_done(checksum_done), .checksum_fail(checksum_fail),
      .enable_reset_pulse(enable_reset_pulse),
      .gates_release(gates_release), .pump_stop(pump_stop),
      .alarm_pin_low(alarm_pin_low),
      .drain_source_trip_level(drain_source_trip_level), .irq(irq)
   );

   fet_stage_model fet_stage_model_inst
   (
      .pclk(pclk), .presetn(presetn), .fet_cmd(fet_cmd),
      .overload(overload), .gates_release(gates_release),
      .fet_enabled(fet_enabled), .drain_source_over(drain_source_over)
   );

   // free-running 125 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // verdict and end of run
   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // compare one value, count and report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer: setup, then access until pready
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50)
      begin
         n++;
         @(posedge pclk);
      end
      chk({31'h0, pready}, 32'h0000_0001);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask

   // gate release and alarm pin together
   task automatic pins(input logic g, input logic a);
      chk({30'h0, gates_release, alarm_pin_low}, {30'h0, g, a});
   endtask

   // clear command keeping the other control fields
   task automatic clr(input logic [31:0] ctl);
      wr(`ADDR_CONTROL, ctl | 32'h0000_0001);
   endtask

   task automatic do_reset(input logic s);
      strap_variant <= s;
      presetn <= 1'b0;
      cyc(2);
      presetn <= 1'b1;
      cyc(1);
   endtask

   // watchdog: the tests need about 3300 cycles
   initial
   begin
      #(8 * 20000);
      errors++;
      close_out();
   end

   // main sequence
   initial
   begin
      errors = 0;
      checks_done = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      strap_variant = 1'b0;
      strap_off = 1'b0;
      supply_lockout = 1'b0;
      pump_low = 1'b0;
      fet_cmd = 6'h3F;
      overload = 6'h00;
      checksum_done = 1'b0;
      checksum_fail = 1'b0;
      enable_reset_pulse = 1'b0;
      do_reset(1'b0);
      // reset values and unmapped access
      rdchk(`ADDR_CONTROL, 32'h0000_0000);
      rdchk(`ADDR_STATUS, 32'h0000_0000);
      rdchk(`ADDR_IRQ_MASK, 32'h0000_0000);
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk({31'h0, err}, 32'h0000_0001);
      pins(1'b0, 1'b1);
      // supply lockout, interrupt masked then unmasked
      supply_lockout <= 1'b1;
      cyc(2);
      pins(1'b1, 1'b0);
      chk({31'h0, pump_stop}, 32'h0000_0001);
      rdchk(`ADDR_STATUS, 32'h0000_0003);
      chk({31'h0, irq}, 32'h0000_0000);
      wr(`ADDR_IRQ_MASK, 32'h0000_0001);
      cyc(1);
      chk({31'h0, irq}, 32'h0000_0001);
      supply_lockout <= 1'b0;
      cyc(2);
      pins(1'b0, 1'b1);
      chk({31'h0, pump_stop}, 32'h0000_0000);
      rdchk(`ADDR_STATUS, 32'h0000_0003);
      wr(`ADDR_IRQ_STATUS, 32'h0000_0001);
      cyc(1);
      chk({31'h0, irq}, 32'h0000_0000);
      clr(32'h0000_0000);
      rdchk(`ADDR_STATUS, 32'h0000_0000);
      rdchk(`ADDR_CONTROL, 32'h0000_0000);
      // pump low unmasked, cleared by enable pulse
      pump_low <= 1'b1;
      cyc(2);
      pins(1'b1, 1'b0);
      chk({31'h0, pump_stop}, 32'h0000_0000);
      rdchk(`ADDR_STATUS, 32'h0000_0005);
      pump_low <= 1'b0;
      cyc(2);
      pins(1'b0, 1'b1);
      enable_reset_pulse <= 1'b1;
      cyc(1);
      enable_reset_pulse <= 1'b0;
      rdchk(`ADDR_STATUS, 32'h0000_0000);
      // pump low masked: flag only
      wr(`ADDR_CONTROL, 32'h0000_0002);
      pump_low <= 1'b1;
      cyc(2);
      pins(1'b0, 1'b1);
      pump_low <= 1'b0;
      rdchk(`ADDR_STATUS, 32'h0000_0005);
      clr(32'h0000_0002);
      rdchk(`ADDR_STATUS, 32'h0000_0000);
      // latched overcurrent, filter code 1 = 250 cycles, level 5
      wr(`ADDR_CONTROL, 32'h0000_1500);
      cyc(1);
      chk({28'h0, drain_source_trip_level}, 32'h0000_0005);
      fet_cmd <= 6'h3E;
      overload <= 6'h01;
      cyc(300);
      rdchk(`ADDR_STATUS, 32'h0000_0000);
      fet_cmd <= 6'h3F;
      cyc(200);
      rdchk(`ADDR_STATUS, 32'h0000_0000);
      cyc(80);
      pins(1'b1, 1'b0);
      rdchk(`ADDR_STATUS, 32'h0000_0029);
      overload <= 6'h00;
      cyc(20);
      pins(1'b1, 1'b0);
      clr(32'h0000_1500);
      cyc(2);
      pins(1'b0, 1'b1);
      rdchk(`ADDR_STATUS, 32'h0000_0000);
      // automatic retry
      wr(`ADDR_CONTROL, 32'h0000_0004);
      overload <= 6'h01;
      cyc(150);
      pins(1'b1, 1'b0);
      overload <= 6'h00;
      rdchk(`ADDR_STATUS, 32'h0000_0029);
      cyc(RETRY);
      pins(1'b0, 1'b1);
      rdchk(`ADDR_STATUS, 32'h0000_0000);
      // report only
      wr(`ADDR_CONTROL, 32'h0000_0008);
      overload <= 6'h01;
      cyc(150);
      pins(1'b0, 1'b0);
      overload <= 6'h00;
      rdchk(`ADDR_STATUS, 32'h0000_0029);
      pins(1'b0, 1'b0);
      clr(32'h0000_0008);
      cyc(2);
      pins(1'b0, 1'b1);
      // disabled: monitor off, bridge masks locked
      wr(`ADDR_CONTROL, 32'h0000_000C);
      wr(`ADDR_CONTROL, 32'h0000_007C);
      rdchk(`ADDR_CONTROL, 32'h0000_000C);
      overload <= 6'h3F;
      cyc(300);
      pins(1'b0, 1'b1);
      rdchk(`ADDR_STATUS, 32'h0000_0000);
      overload <= 6'h00;
      // leaving disabled unlocks the bridge masks, which then gate trips
      wr(`ADDR_CONTROL, 32'h0000_0008);
      wr(`ADDR_CONTROL, 32'h0000_0078);
      rdchk(`ADDR_CONTROL, 32'h0000_0078);
      overload <= 6'h3F;
      cyc(300);
      pins(1'b0, 1'b1);
      rdchk(`ADDR_STATUS, 32'h0000_0000);
      overload <= 6'h00;
      // strapped variant: no pump mask, fixed filter, latched
      do_reset(1'b1);
      wr(`ADDR_CONTROL, 32'h0000_0006);
      pump_low <= 1'b1;
      cyc(2);
      pins(1'b1, 1'b0);
      pump_low <= 1'b0;
      clr(32'h0000_0006);
      rdchk(`ADDR_STATUS, 32'h0000_0000);
      overload <= 6'h01;
      cyc(300);
      rdchk(`ADDR_STATUS, 32'h0000_0000);
      cyc(250);
      pins(1'b1, 1'b0);
      overload <= 6'h00;
      cyc(RETRY + 20);
      rdchk(`ADDR_STATUS, 32'h0000_0029);
      clr(32'h0000_0006);
      rdchk(`ADDR_STATUS, 32'h0000_0000);
      strap_off <= 1'b1;
      overload <= 6'h01;
      cyc(600);
      pins(1'b0, 1'b1);
      overload <= 6'h00;
      // memory checksum fault: alarm only, never cleared
      checksum_done <= 1'b1;
      checksum_fail <= 1'b1;
      cyc(1);
      checksum_done <= 1'b0;
      checksum_fail <= 1'b0;
      cyc(2);
      pins(1'b0, 1'b0);
      rdchk(`ADDR_STATUS, 32'h0000_0011);
      clr(32'h0000_0006);
      rdchk(`ADDR_STATUS, 32'h0000_0011);
      rdchk(`ADDR_LIVE, 32'h0000_0008);
      close_out();
   end
endmodule
